// *** dv/modbus_master_model.sv ***
// bus master model: sends query bytes and collects reply bytes
`timescale 1ns/100ps
module modbus_master_model (
    input wire logic clk_sys_i,
    input wire logic slow_i,
    input wire logic tx_valid_i,
    input wire logic tx_last_i,
    input wire logic [7:0] tx_byte_i,
    output logic [7:0] rx_byte_o,
    output logic rx_valid_o,
    output logic rx_last_o,
    output logic rx_crc_ok_o,
    output logic tx_ready_o
);
    logic [7:0] got[$];
    int last_pos = -1;
    logic toggle_reg = 1'b0;
    initial begin
        rx_byte_o = 8'h00;
        rx_valid_o = 1'b0;
        rx_last_o = 1'b0;
        rx_crc_ok_o = 1'b1;
    end
    // stalls every other cycle when slow
    assign tx_ready_o = !slow_i | toggle_reg;
    always @(posedge clk_sys_i) begin
        toggle_reg <= !toggle_reg;
        if (tx_valid_i === 1'b1 && tx_ready_o) begin
            if (tx_last_i === 1'b1) begin
                last_pos = got.size();
            end
            got.push_back(tx_byte_i);
        end
    end
    // one byte a cycle, line shows inverse of last byte when idle
    task automatic send_frame(input logic [7:0] f[$]);
        for (int i = 0; i < f.size(); i++) begin
            @(posedge clk_sys_i);
            rx_byte_o <= f[i];
            rx_valid_o <= 1'b1;
            rx_last_o <= (i == f.size() - 1);
        end
        @(posedge clk_sys_i);
        rx_valid_o <= 1'b0;
        rx_last_o <= 1'b0;
        rx_byte_o <= ~f[f.size() - 1];
    endtask : send_frame
endmodule : modbus_master_model

// *** dv/modbus_slave_write_loopback_test.sv ***
// self-checking bench for the modbus slave write and loopback handler
`timescale 1ns/100ps
module modbus_slave_write_loopback_test;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] slave_addr_i = 8'h08;
    logic [7:0] run_command_source_select_i = 8'h03;
    logic hreg_fail_i = 1'b0;
    logic slow_i = 1'b0;
    logic [7:0] rx_byte_i, tx_byte_o;
    logic rx_valid_i, rx_last_i, rx_crc_ok_i, tx_ready_i, busy_o, tx_valid_o, run_cmd_o, tx_last_o, hreg_wr_o;
    logic [30:0] coils_o;
    logic [15:0] hreg_num_o, hreg_data_o;
    logic [7:0] none[$];
    int n_fail = 0;
    int checks = 0;
    int n_wr = 0;
    always #2 clk_sys_i = ~clk_sys_i;
    // counts register store pulses
    always @(posedge clk_sys_i) begin
        if (hreg_wr_o === 1'b1) begin
            n_wr++;
        end
    end

    modbus_slave_write_loopback #(.COIL_COUNT(31)) i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .slave_addr_i(slave_addr_i), .run_command_source_select_i(run_command_source_select_i),
        .rx_byte_i(rx_byte_i), .rx_valid_i(rx_valid_i), .rx_last_i(rx_last_i), .rx_crc_ok_i(rx_crc_ok_i),
        .tx_ready_i(tx_ready_i), .hreg_fail_i(hreg_fail_i), .busy_o(busy_o), .tx_byte_o(tx_byte_o),
        .tx_valid_o(tx_valid_o), .tx_last_o(tx_last_o), .coils_o(coils_o), .run_cmd_o(run_cmd_o), .hreg_wr_o(hreg_wr_o),
        .hreg_num_o(hreg_num_o), .hreg_data_o(hreg_data_o));
    modbus_master_model i_master (.clk_sys_i(clk_sys_i), .slow_i(slow_i), .tx_valid_i(tx_valid_o),
        .tx_last_i(tx_last_o), .tx_byte_i(tx_byte_o), .rx_byte_o(rx_byte_i), .rx_valid_o(rx_valid_i),
        .rx_last_o(rx_last_i), .rx_crc_ok_o(rx_crc_ok_i), .tx_ready_o(tx_ready_i));

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] seen);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict
    // sends a query, waits for the handler to go idle, compares the reply
    task automatic query(input logic [7:0] f[$], input logic [7:0] exp[$]);
        i_master.got.delete();
        i_master.last_pos = -1;
        i_master.send_frame(f);
        repeat (2) @(negedge clk_sys_i);
        for (int i = 0; i < 300 && busy_o !== 1'b0; i++) @(negedge clk_sys_i);
        if (busy_o !== 1'b0) begin
            n_fail++;
            $display("ERROR busy expected 0 seen %b", busy_o);
            give_verdict();
        end
        check("reply length", 16'(exp.size()), 16'(i_master.got.size()));
        check("reply last flag", 16'(exp.size() - 1), 16'(i_master.last_pos));
        for (int i = 0; i < exp.size() && i < i_master.got.size(); i++) begin
            check("reply byte", {8'h00, exp[i]}, {8'h00, i_master.got[i]});
        end
    endtask : query
    task automatic set_select(input logic [7:0] v);
        @(posedge clk_sys_i);
        run_command_source_select_i <= v;
        repeat (2) @(negedge clk_sys_i);
    endtask : set_select

    task automatic test_coil();
        query('{8'h08, 8'h05, 8'h00, 8'h00, 8'hff, 8'h00}, '{8'h08, 8'h05, 8'h00, 8'h00, 8'hff, 8'h00});
        check("coil 1", 16'h0001, 16'(coils_o[0]));
        check("run", 16'h0001, 16'(run_cmd_o));
        set_select(8'h00);
        check("run other source", 16'h0000, 16'(run_cmd_o));
        set_select(8'h03);
        query('{8'h08, 8'h05, 8'h00, 8'h1e, 8'hff, 8'h00}, '{8'h08, 8'h05, 8'h00, 8'h1e, 8'hff, 8'h00});
        check("coil 31", 16'h0001, 16'(coils_o[30]));
        query('{8'h08, 8'h05, 8'h00, 8'h01, 8'h12, 8'h34}, '{8'h08, 8'h85, 8'h03});
        check("coil 2", 16'h0000, 16'(coils_o[1]));
        query('{8'h08, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00}, '{8'h08, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00});
        check("coil 1 off", 16'h0000, 16'(coils_o[0]));
        check("run off", 16'h0000, 16'(run_cmd_o));
        check("register writes", 16'h0000, 16'(n_wr));
        $display("test coil done");
    endtask : test_coil
    task automatic test_hreg();
        query('{8'h08, 8'h06, 8'h10, 8'h28, 8'h01, 8'hf4}, '{8'h08, 8'h06, 8'h10, 8'h28, 8'h01, 8'hf4});
        check("hreg number", 16'h1029, hreg_num_o);
        check("hreg data", 16'h01f4, hreg_data_o);
        check("register writes", 16'h0001, 16'(n_wr));
        @(posedge clk_sys_i);
        hreg_fail_i <= 1'b1;
        query('{8'h08, 8'h06, 8'h00, 8'h00, 8'h00, 8'h05}, '{8'h08, 8'h86, 8'h04});
        check("register writes", 16'h0002, 16'(n_wr));
        @(posedge clk_sys_i);
        hreg_fail_i <= 1'b0;
        $display("test hreg done");
    endtask : test_hreg
    task automatic test_loop();
        @(posedge clk_sys_i);
        slow_i <= 1'b1;
        query('{8'h08, 8'h08, 8'h00, 8'h00, 8'hab, 8'hcd}, '{8'h08, 8'h08, 8'h00, 8'h00, 8'hab, 8'hcd});
        query('{8'h08, 8'h08, 8'h00, 8'h01, 8'hab, 8'hcd}, '{8'h08, 8'h88, 8'h01});
        @(posedge clk_sys_i);
        slow_i <= 1'b0;
        $display("test loopback done");
    endtask : test_loop
    task automatic test_multi();
        // byte count padded to even by the master
        query('{8'h08, 8'h0f, 8'h00, 8'h06, 8'h00, 8'h05, 8'h02, 8'h17, 8'h00},
              '{8'h08, 8'h0f, 8'h00, 8'h06, 8'h00, 8'h05});
        check("coils 7 to 11", 16'h0017, {11'h000, coils_o[10:6]});
        check("coils 12 to 27", 16'h0000, coils_o[26:11]);
        check("coils 28 to 31", 16'h0008, {12'h000, coils_o[30:27]});
        check("coils 1 to 6", 16'h0000, {10'h000, coils_o[5:0]});
        $display("test multiple coils done");
    endtask : test_multi
    task automatic test_refuse();
        query('{8'h08, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h08, 8'h83, 8'h01});
        query('{8'h08, 8'h05, 8'h00, 8'h1f, 8'hff, 8'h00}, '{8'h08, 8'h85, 8'h02});
        query('{8'h08, 8'h0f, 8'h00, 8'h1e, 8'h00, 8'h02, 8'h02, 8'h00, 8'h00},
              '{8'h08, 8'h8f, 8'h02});
        check("coil 31 kept", 16'h0001, 16'(coils_o[30]));
        query('{8'h08, 8'h06, 8'h00, 8'h00, 8'h00}, '{8'h08, 8'h86, 8'h03});
        check("register writes", 16'h0002, 16'(n_wr));
        $display("test refusals done");
    endtask : test_refuse
    task automatic test_bcast();
        query('{8'h00, 8'h05, 8'h00, 8'h01, 8'hff, 8'h00}, none);
        check("broadcast coil 2", 16'h0001, 16'(coils_o[1]));
        query('{8'h00, 8'h06, 8'h00, 8'h10, 8'h55, 8'haa}, none);
        check("broadcast hreg", 16'h55aa, hreg_data_o);
        check("broadcast hreg number", 16'h0011, hreg_num_o);
        check("register writes", 16'h0003, 16'(n_wr));
        query('{8'h00, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34}, none);
        query('{8'h00, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h01, 8'h00}, none);
        check("broadcast coils", 16'h0000, 16'(coils_o[0]));
        $display("test broadcast done");
    endtask : test_bcast

    initial begin
        repeat (16) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        test_coil();
        test_hreg();
        test_loop();
        test_multi();
        test_refuse();
        test_bcast();
        give_verdict();
    end
endmodule : modbus_slave_write_loopback_test

// *** rtl/modbus_slave_pkg.sv ***
// constants and state codes for the modbus slave write and loopback handler
package modbus_slave_pkg;
    localparam logic [7:0] FN_WRITE_COIL = 8'h05;
    localparam logic [7:0] FN_WRITE_HREG = 8'h06;
    localparam logic [7:0] FN_LOOPBACK = 8'h08;
    localparam logic [7:0] FN_WRITE_COILS = 8'h0F;
    localparam logic [7:0] EXC_FLAG = 8'h80;
    localparam logic [7:0] BCAST_ADDR = 8'h00;
    localparam logic [7:0] RUN_SRC_SERIAL = 8'h03;
    localparam logic [15:0] COIL_ON = 16'hFF00;
    localparam logic [15:0] COIL_OFF = 16'h0000;
    localparam logic [15:0] LOOP_ECHO = 16'h0000;
    localparam logic [15:0] HREG_NUM_OFFSET = 16'h0001;
    localparam logic [7:0] EXC_NONE = 8'h00;
    localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
    localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
    localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
    localparam logic [7:0] EXC_DEVICE_FAIL = 8'h04;
    localparam logic [3:0] FRAME_DEPTH = 4'hC;
    localparam logic [3:0] SINGLE_LEN = 4'h6;
    localparam logic [8:0] MULTI_HDR_LEN = 9'h007;
    localparam logic [7:0] MULTI_MAX_BYTES = 8'h04;
    localparam logic [3:0] NORMAL_LAST = 4'h5;
    localparam logic [3:0] EXC_LAST = 4'h2;

    typedef enum logic [3:0] {
        ST_RX = 4'b0001,
        ST_EXEC = 4'b0010,
        ST_WAIT = 4'b0100,
        ST_TX = 4'b1000
    } state_e;
endpackage : modbus_slave_pkg

// *** rtl/modbus_slave_write_loopback.sv ***
// modbus slave handler for single/multiple coil write, register write and loopback
`timescale 1ns/100ps

// Functional notes
// - single coil data FF00h sets the coil on, 0000h sets it off
// - coil number 1 is the run command
// - run command passes only when source select equals 03
// - coil address on the line is coil number minus one
// - register number is line address plus one
// - function 06h stores the 16-bit high/low change value in one register
// - broadcast 05h or 06h executes with no reply
// - failed register write answers with an exception
// - function 08h echoes subcode and data unchanged
// - only loopback subcode 0000h is supported, others are refused
// - broadcast 08h or 0Fh is neither executed nor answered
// - function 0Fh sets count consecutive coils from packed data
// - bit 0 of first data byte is the first addressed coil
// - exception reply carries function plus 80h and an exception code
module modbus_slave_write_loopback #(
    parameter int COIL_COUNT = 31
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [7:0] slave_addr_i,
    input wire logic [7:0] run_command_source_select_i,
    input wire logic [7:0] rx_byte_i,
    input wire logic rx_valid_i,
    input wire logic rx_last_i,
    input wire logic rx_crc_ok_i,
    input wire logic tx_ready_i,
    input wire logic hreg_fail_i,
    output logic busy_o,
    output logic [7:0] tx_byte_o,
    output logic tx_valid_o,
    output logic tx_last_o,
    output logic [COIL_COUNT-1:0] coils_o,
    output logic run_cmd_o,
    output logic hreg_wr_o,
    output logic [15:0] hreg_num_o,
    output logic [15:0] hreg_data_o
);
    localparam logic [16:0] COILS_W = 17'(COIL_COUNT);

    modbus_slave_pkg::state_e state_reg, state_next;
    logic [7:0] frame_reg [0:11];
    logic [3:0] rx_cnt_reg, rx_cnt_next, len_reg;
    logic ovf_reg, ovf_next, big_reg;
    logic [COIL_COUNT-1:0] coils_reg, coils_next;
    logic run_reg, busy_reg, hreg_wr_reg;
    logic [15:0] hreg_num_reg, hreg_data_reg;
    logic exc_reg;
    logic [7:0] exc_code_reg, exc_code_w;
    logic [3:0] tx_idx_reg;
    logic [7:0] tx_byte_reg;
    logic tx_valid_reg, tx_last_reg;

    // frame field decode
    wire [7:0] fn_w = frame_reg[1];
    wire [15:0] addr_w = {frame_reg[2], frame_reg[3]};
    wire [15:0] data_w = {frame_reg[4], frame_reg[5]};
    wire [7:0] bcnt_w = frame_reg[6];
    wire [31:0] bits_w = {frame_reg[10], frame_reg[9], frame_reg[8], frame_reg[7]};
    wire bcast_w = frame_reg[0] == modbus_slave_pkg::BCAST_ADDR;
    wire mine_w = bcast_w || (frame_reg[0] == slave_addr_i);
    wire exec_w = (state_reg == modbus_slave_pkg::ST_EXEC) && mine_w;
    wire [16:0] end_w = {1'b0, addr_w} + {1'b0, data_w};
    wire [7:0] need_w = (8'(data_w[5:0]) + 8'h07) >> 3;

    // receive side
    wire rx_take_w = (state_reg == modbus_slave_pkg::ST_RX) && rx_valid_i;
    wire rx_room_w = rx_cnt_reg < modbus_slave_pkg::FRAME_DEPTH;
    wire rx_done_w = rx_take_w && rx_last_i;
    assign rx_cnt_next = !rx_take_w ? rx_cnt_reg : rx_last_i ? 4'h0 : rx_room_w ? rx_cnt_reg + 4'h1 : rx_cnt_reg;
    assign ovf_next = !rx_take_w ? ovf_reg : rx_last_i ? 1'b0 : ovf_reg | !rx_room_w;

    // validation
    wire single_len_ok_w = !big_reg && (len_reg == modbus_slave_pkg::SINGLE_LEN);
    wire coil_val_ok_w = (data_w == modbus_slave_pkg::COIL_ON) || (data_w == modbus_slave_pkg::COIL_OFF);
    wire coil_addr_ok_w = {1'b0, addr_w} < COILS_W;
    // byte count is taken as sent; padding to even is the master's job
    wire multi_len_ok_w = !big_reg && ({5'h00, len_reg} == {1'b0, bcnt_w} + modbus_slave_pkg::MULTI_HDR_LEN)
        && (bcnt_w >= need_w) && (bcnt_w <= modbus_slave_pkg::MULTI_MAX_BYTES);
    wire multi_cnt_ok_w = (data_w != 16'h0000) && ({1'b0, data_w} <= COILS_W);
    wire multi_rng_ok_w = end_w <= COILS_W;
    wire is_single_w = (fn_w == modbus_slave_pkg::FN_WRITE_COIL) || (fn_w == modbus_slave_pkg::FN_WRITE_HREG);

    always_comb begin
        exc_code_w = modbus_slave_pkg::EXC_NONE;
        case (fn_w)
            modbus_slave_pkg::FN_WRITE_COIL: begin
                if (!single_len_ok_w || !coil_val_ok_w) exc_code_w = modbus_slave_pkg::EXC_ILLEGAL_VALUE;
                else if (!coil_addr_ok_w) exc_code_w = modbus_slave_pkg::EXC_ILLEGAL_ADDR;
            end
            modbus_slave_pkg::FN_WRITE_HREG: begin
                if (!single_len_ok_w) exc_code_w = modbus_slave_pkg::EXC_ILLEGAL_VALUE;
            end
            modbus_slave_pkg::FN_LOOPBACK: begin
                if (!single_len_ok_w) exc_code_w = modbus_slave_pkg::EXC_ILLEGAL_VALUE;
                else if (addr_w != modbus_slave_pkg::LOOP_ECHO) exc_code_w = modbus_slave_pkg::EXC_ILLEGAL_FUNC;
            end
            modbus_slave_pkg::FN_WRITE_COILS: begin
                if (!multi_len_ok_w || !multi_cnt_ok_w) exc_code_w = modbus_slave_pkg::EXC_ILLEGAL_VALUE;
                else if (!multi_rng_ok_w) exc_code_w = modbus_slave_pkg::EXC_ILLEGAL_ADDR;
            end
            default: exc_code_w = modbus_slave_pkg::EXC_ILLEGAL_FUNC;
        endcase
    end

    // broadcast runs only single writes
    wire go_w = exec_w && (exc_code_w == modbus_slave_pkg::EXC_NONE) && (!bcast_w || is_single_w);
    wire single_hit_w = go_w && (fn_w == modbus_slave_pkg::FN_WRITE_COIL);
    wire multi_hit_w = go_w && (fn_w == modbus_slave_pkg::FN_WRITE_COILS);
    wire hreg_hit_w = go_w && (fn_w == modbus_slave_pkg::FN_WRITE_HREG);

    // coil update, bit i is coil number i+1
    for (genvar i = 0; i < COIL_COUNT; i++) begin : g_coil
        localparam logic [16:0] IDX = 17'(i);
        wire in_rng_w = ({1'b0, addr_w} <= IDX) && (IDX < end_w);
        wire [16:0] off_w = IDX - {1'b0, addr_w};
        assign coils_next[i] = (single_hit_w && (addr_w == IDX[15:0])) ? (data_w == modbus_slave_pkg::COIL_ON)
            : (multi_hit_w && in_rng_w) ? bits_w[off_w[4:0]] : coils_reg[i];
    end

    // sequencing
    wire tx_fire_w = tx_valid_reg && tx_ready_i;
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            modbus_slave_pkg::ST_RX: if (rx_done_w && rx_crc_ok_i) state_next = modbus_slave_pkg::ST_EXEC;
            modbus_slave_pkg::ST_EXEC: begin
                if (!mine_w) state_next = modbus_slave_pkg::ST_RX;
                else if (hreg_hit_w) state_next = modbus_slave_pkg::ST_WAIT;
                else if (bcast_w) state_next = modbus_slave_pkg::ST_RX;
                else state_next = modbus_slave_pkg::ST_TX;
            end
            modbus_slave_pkg::ST_WAIT: state_next = bcast_w ? modbus_slave_pkg::ST_RX : modbus_slave_pkg::ST_TX;
            modbus_slave_pkg::ST_TX: if (tx_fire_w && tx_last_reg) state_next = modbus_slave_pkg::ST_RX;
        endcase
    end

    // reply bytes: echo of first six bytes, or address, function+80h, code
    wire tx_start_w = (state_next == modbus_slave_pkg::ST_TX) && (state_reg != modbus_slave_pkg::ST_TX);
    wire [3:0] tx_idx_next = tx_start_w ? 4'h0 : tx_fire_w ? tx_idx_reg + 4'h1 : tx_idx_reg;
    wire [3:0] tx_end_w = exc_reg ? modbus_slave_pkg::EXC_LAST : modbus_slave_pkg::NORMAL_LAST;
    wire [7:0] tx_byte_next = (exc_reg && tx_idx_next == 4'h1) ? (fn_w | modbus_slave_pkg::EXC_FLAG)
        : (exc_reg && tx_idx_next == 4'h2) ? exc_code_reg : frame_reg[tx_idx_next];
    wire tx_valid_next = tx_start_w | (tx_valid_reg & ~(tx_fire_w & tx_last_reg));
    wire wait_fail_w = (state_reg == modbus_slave_pkg::ST_WAIT) && hreg_fail_i;

    always_ff @(posedge clk_sys_i) begin
        if (rx_take_w && rx_room_w) frame_reg[rx_cnt_reg] <= rx_byte_i;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= modbus_slave_pkg::ST_RX;
            rx_cnt_reg <= 4'h0;
            ovf_reg <= 1'b0;
            len_reg <= 4'h0;
            big_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            rx_cnt_reg <= rx_cnt_next;
            ovf_reg <= ovf_next;
            busy_reg <= state_next != modbus_slave_pkg::ST_RX;
            if (rx_done_w) begin
                len_reg <= rx_room_w ? rx_cnt_reg + 4'h1 : rx_cnt_reg;
                big_reg <= ovf_reg | !rx_room_w;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            coils_reg <= '0;
            run_reg <= 1'b0;
            hreg_wr_reg <= 1'b0;
            hreg_num_reg <= 16'h0000;
            hreg_data_reg <= 16'h0000;
        end else begin
            coils_reg <= coils_next;
            run_reg <= coils_reg[0] && (run_command_source_select_i == modbus_slave_pkg::RUN_SRC_SERIAL);
            hreg_wr_reg <= hreg_hit_w;
            if (hreg_hit_w) begin
                hreg_num_reg <= addr_w + modbus_slave_pkg::HREG_NUM_OFFSET;
                hreg_data_reg <= data_w;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            exc_reg <= 1'b0;
            exc_code_reg <= modbus_slave_pkg::EXC_NONE;
            tx_idx_reg <= 4'h0;
            tx_byte_reg <= 8'h00;
            tx_valid_reg <= 1'b0;
            tx_last_reg <= 1'b0;
        end else begin
            if (exec_w) begin
                exc_reg <= exc_code_w != modbus_slave_pkg::EXC_NONE;
                exc_code_reg <= exc_code_w;
            end else if (wait_fail_w) begin
                exc_reg <= 1'b1;
                exc_code_reg <= modbus_slave_pkg::EXC_DEVICE_FAIL;
            end
            tx_idx_reg <= tx_idx_next;
            tx_byte_reg <= tx_byte_next;
            tx_valid_reg <= tx_valid_next;
            tx_last_reg <= tx_valid_next && !tx_start_w && (tx_idx_next == tx_end_w);
        end
    end

    assign busy_o = busy_reg;
    assign tx_byte_o = tx_byte_reg;
    assign tx_valid_o = tx_valid_reg;
    assign tx_last_o = tx_last_reg;
    assign coils_o = coils_reg;
    assign run_cmd_o = run_reg;
    assign hreg_wr_o = hreg_wr_reg;
    assign hreg_num_o = hreg_num_reg;
    assign hreg_data_o = hreg_data_reg;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    sequence bcast_exec_s;
        (state_reg == modbus_slave_pkg::ST_EXEC) && bcast_w;
    endsequence
    sequence loop_bad_s;
        exec_w && !bcast_w && (fn_w == modbus_slave_pkg::FN_LOOPBACK) && single_len_ok_w
            && (addr_w != modbus_slave_pkg::LOOP_ECHO);
    endsequence
    sequence exc_reply_s;
        exc_reg && (exc_code_reg == modbus_slave_pkg::EXC_ILLEGAL_FUNC) && tx_valid_o && (tx_idx_reg == 4'h0)
            && (tx_byte_o == frame_reg[0])
            ##1 tx_valid_o && exc_reg && ((tx_idx_reg == 4'h0) || (tx_idx_reg == 4'h1));
    endsequence

    chk_coil_single_value: assert property (single_hit_w |=>
        coils_o[$past(addr_w[4:0])] == ($past(data_w) == modbus_slave_pkg::COIL_ON))
        else $error("single coil write stored wrong state");
    chk_run_gate_on: assert property ((coils_o[0] && run_command_source_select_i == modbus_slave_pkg::RUN_SRC_SERIAL)
        |=> run_cmd_o)
        else $error("run command not raised from coil 1");
    chk_run_gate_off: assert property ((run_command_source_select_i != modbus_slave_pkg::RUN_SRC_SERIAL)
        |=> !run_cmd_o)
        else $error("run command passed with wrong source");
    chk_hreg_number_data: assert property (hreg_wr_o |->
        (hreg_num_o == addr_w + modbus_slave_pkg::HREG_NUM_OFFSET) && (hreg_data_o == data_w))
        else $error("register number or data wrong");
    chk_hreg_write_pulse: assert property (hreg_hit_w |=> hreg_wr_o ##1 !hreg_wr_o)
        else $error("register write pulse missing");
    chk_bcast_silent: assert property (bcast_exec_s |=> !tx_valid_o [*3])
        else $error("broadcast query answered");
    chk_bcast_no_multi: assert property ((bcast_exec_s and (fn_w != modbus_slave_pkg::FN_WRITE_COIL)
        and (fn_w != modbus_slave_pkg::FN_WRITE_HREG)) |=> $stable(coils_o) && !hreg_wr_o)
        else $error("broadcast multi or loopback executed");
    chk_exc_func_code: assert property ((tx_valid_o && exc_reg && tx_idx_reg == 4'h1) |->
        tx_byte_o == (fn_w | modbus_slave_pkg::EXC_FLAG))
        else $error("exception function code wrong");
    chk_loop_subcode: assert property (loop_bad_s |=> exc_reply_s)
        else $error("bad loopback subcode not refused");
    chk_echo_bytes: assert property ((tx_valid_o && !exc_reg) |-> tx_byte_o == frame_reg[tx_idx_reg])
        else $error("normal reply byte differs from query");
    chk_reply_length: assert property ((tx_valid_o && tx_last_o) |->
        tx_idx_reg == (exc_reg ? modbus_slave_pkg::EXC_LAST : modbus_slave_pkg::NORMAL_LAST))
        else $error("reply length wrong");
    chk_multi_first_bit: assert property (multi_hit_w |=> coils_o[$past(addr_w[4:0])] == $past(bits_w[0]))
        else $error("first addressed coil not from data bit 0");
    chk_exc_on_fail: assert property ((state_reg == modbus_slave_pkg::ST_WAIT && hreg_fail_i && !bcast_w)
        |=> exc_reg && (exc_code_reg == modbus_slave_pkg::EXC_DEVICE_FAIL) && tx_valid_o && (tx_idx_reg == 4'h0))
        else $error("register failure not answered with exception");
endmodule : modbus_slave_write_loopback
